// ### iox_pkg.sv
// Purpose: Shared constants and types for the serial-bus port expander
// Assumes: Link side oversamples the serial bus on its own clock
// Notes: Times are in ns; cycle counts derive from them
package iox_pkg;
	localparam int PORT_W = 8;
	localparam int STRAP_W = 3;
	localparam int PREFIX_W = 4;
	localparam logic [PORT_W-1:0] LATCH_RST = 8'hFF;
	localparam logic [PORT_W-1:0] REF_RST = 8'hFF;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int LINK_PERIOD_NS = 12;
	localparam int SPIKE_NS = 50;
	// Least time, so round up
	localparam int SPIKE_CYC_I = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam logic [3:0] SPIKE_CYC = 4'(SPIKE_CYC_I < 1 ? 1 : SPIKE_CYC_I);
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_ADDR,
		LS_ADDR_ACK,
		LS_WR_DATA,
		LS_WR_ACK,
		LS_RD_DATA,
		LS_RD_ACK
	} iox_link_state_t;
endpackage

// ### iox_expander.sv
// Purpose: Serial-bus slave driving eight quasi-bidirectional port lines
// Assumes: scl/sda/ports/straps are asynchronous pins; link_clk oversamples the bus
// Notes: Port, latch and interrupt live on clk; bus engine lives on link_clk
//
// Functional notes
// RULE1 - One data bit per clock pulse; data changes while clock high are controls
// RULE2 - Data fall with clock high starts; data rise with clock high stops
// RULE3 - Master starts a new transfer only while the bus is idle
// RULE4 - Each byte of eight bits is followed by one acknowledge slot
// RULE5 - Unlimited bytes per transfer; keep writing or reading until stop
// RULE6 - Addressed as receiver, acknowledge each byte by pulling data low
// RULE7 - Master acknowledges each read byte except the final one
// RULE8 - Acknowledger holds data low across the whole acknowledge clock high
// RULE9 - Missing master acknowledge ends a read; expander releases data high
// RULE10 - Compare three address bits with three strap pins
// RULE11 - Each port line works as input or output with no direction control
// RULE12 - Read returns sampled port levels; write loads the output latch
// RULE13 - Stop keeps latch from last acknowledge; partial bytes are dropped
// RULE14 - Any edge on an input port line asserts the interrupt output
// RULE15 - Interrupt clears when input returns, or on access to this expander
// RULE16 - Read clears at acknowledge clock rise; write at acknowledge clock fall
// RULE17 - Input changes during the acknowledge pulse may be lost or brief
// RULE18 - After a clear, every further change asserts interrupt after next clock
// RULE19 - Transfers to other devices leave interrupt state untouched
// RULE20 - Port lines come up high with only weak pull-up
// RULE21 - Line written high gets strong pull-up until the next clock fall; code boosts only lines that were low before the write
// RULE22 - Master should write a line high before using it as input
// RULE23 - Address byte is prefix, three strap bits, then direction bit (one reads)
// RULE24 - Bus lines synchronised and filtered; port inputs synchronised
`timescale 1ns/100ps
module iox_expander #(
	parameter logic [iox_pkg::PREFIX_W-1:0] ADDR_PREFIX = 4'h5 // Arbitrary value
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [iox_pkg::STRAP_W-1:0] addr_strap,
	input wire logic [iox_pkg::PORT_W-1:0] port_line_in,
	output logic [iox_pkg::PORT_W-1:0] port_line_out,
	output logic [iox_pkg::PORT_W-1:0] port_line_oe,
	output logic int_n_out,
	output logic int_n_oe
);
	import iox_pkg::*;

	// Link-domain reset: asserts at once, releases on link_clk
	logic rst_lm;
	logic rst_l;
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			rst_lm <= 1'b1;
			rst_l <= 1'b1;
		end
		else
		begin
			rst_lm <= 1'b0;
			rst_l <= rst_lm;
		end
	end

	// Bus pin synchronisers
	logic scl_m;
	logic scl_s;
	logic sda_m;
	logic sda_s;
	logic [STRAP_W-1:0] strap_m;
	logic [STRAP_W-1:0] strap_s;
	always_ff @(posedge link_clk or posedge rst_l)
	begin
		if (rst_l)
		begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			strap_m <= '0;
			strap_s <= '0;
		end
		else
		begin
			scl_m <= scl_in; // see RULE24
			scl_s <= scl_m;
			sda_m <= sda_in;
			sda_s <= sda_m;
			strap_m <= addr_strap;
			strap_s <= strap_m;
		end
	end

	// Spike filter: a level must hold for SPIKE_CYC samples
	logic scl_f;
	logic sda_f;
	logic [3:0] scl_cnt;
	logic [3:0] sda_cnt;
	always_ff @(posedge link_clk or posedge rst_l)
	begin
		if (rst_l)
		begin
			scl_f <= 1'b1;
			scl_cnt <= '0;
		end
		else if (scl_s == scl_f)
			scl_cnt <= '0;
		else if (scl_cnt == SPIKE_CYC - 4'h1)
		begin
			scl_f <= scl_s; // see RULE24
			scl_cnt <= '0;
		end
		else
			scl_cnt <= scl_cnt + 4'h1;
	end

	always_ff @(posedge link_clk or posedge rst_l)
	begin
		if (rst_l)
		begin
			sda_f <= 1'b1;
			sda_cnt <= '0;
		end
		else if (sda_s == sda_f)
			sda_cnt <= '0;
		else if (sda_cnt == SPIKE_CYC - 4'h1)
		begin
			sda_f <= sda_s; // see RULE24
			sda_cnt <= '0;
		end
		else
			sda_cnt <= sda_cnt + 4'h1;
	end

	// Edge and condition detection on filtered lines
	logic scl_p;
	logic sda_p;
	always_ff @(posedge link_clk or posedge rst_l)
	begin
		if (rst_l)
		begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end
		else
		begin
			scl_p <= scl_f;
			sda_p <= sda_f;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_rise = scl_f & ~scl_p;
	assign scl_fall = ~scl_f & scl_p;
	assign start_det = scl_f & scl_p & sda_p & ~sda_f; // see RULE2
	assign stop_det = scl_f & scl_p & ~sda_p & sda_f; // see RULE2

	// Bus engine
	iox_link_state_t state;
	logic [3:0] bit_cnt;
	logic [PORT_W-1:0] rx_shift;
	logic [PORT_W-1:0] tx_shift;
	logic [PORT_W-1:0] wr_data;
	logic rd_dir;
	logic drive_low;
	logic rd_tgl;
	logic wr_tgl;
	logic [PORT_W-1:0] snapshot;
	logic addr_hit;

	// Prefix, straps, then direction bit
	assign addr_hit = (rx_shift[7:4] == ADDR_PREFIX) && (rx_shift[3:1] == strap_s); // see RULE10, RULE23

	always_ff @(posedge link_clk or posedge rst_l)
	begin
		if (rst_l)
		begin
			state <= LS_IDLE;
			bit_cnt <= '0;
			rx_shift <= '0;
			tx_shift <= '0;
			wr_data <= LATCH_RST;
			rd_dir <= 1'b0;
			drive_low <= 1'b0;
			rd_tgl <= 1'b0;
			wr_tgl <= 1'b0;
		end
		else if (stop_det)
		begin
			// Half-shifted bytes simply die here
			state <= LS_IDLE; // see RULE13
			drive_low <= 1'b0;
		end
		else if (start_det)
		begin
			state <= LS_ADDR;
			bit_cnt <= '0;
			drive_low <= 1'b0;
		end
		else if (scl_rise)
		begin
			unique case (state)
				LS_ADDR, LS_WR_DATA:
				begin
					rx_shift <= {rx_shift[PORT_W-2:0], sda_f}; // see RULE1
					bit_cnt <= bit_cnt + 4'h1;
				end
				LS_RD_DATA:
					bit_cnt <= bit_cnt + 4'h1;
				LS_ADDR_ACK:
					if (rd_dir)
						rd_tgl <= ~rd_tgl; // see RULE16, RULE12
				LS_RD_ACK:
					if (!sda_f)
						rd_tgl <= ~rd_tgl; // see RULE7, RULE16
					else
						state <= LS_IDLE; // see RULE9
				LS_IDLE, LS_WR_ACK:
				begin
				end
			endcase
		end
		else if (scl_fall)
		begin
			unique case (state)
				LS_ADDR:
					if (bit_cnt == BITS_PER_BYTE)
					begin
						if (addr_hit)
						begin
							state <= LS_ADDR_ACK;
							rd_dir <= rx_shift[0]; // see RULE23
							drive_low <= 1'b1; // see RULE6
						end
						else
							state <= LS_IDLE; // see RULE19
					end
				LS_ADDR_ACK:
				begin
					bit_cnt <= '0;
					if (rd_dir)
					begin
						state <= LS_RD_DATA;
						tx_shift <= snapshot;
						drive_low <= ~snapshot[PORT_W-1];
					end
					else
					begin
						state <= LS_WR_DATA;
						drive_low <= 1'b0;
					end
				end
				LS_WR_DATA:
					if (bit_cnt == BITS_PER_BYTE) // see RULE4
					begin
						state <= LS_WR_ACK;
						drive_low <= 1'b1; // see RULE6, RULE8
					end
				LS_WR_ACK:
				begin
					// Commit only once the acknowledge completes
					wr_data <= rx_shift; // see RULE12, RULE13
					wr_tgl <= ~wr_tgl; // see RULE16
					drive_low <= 1'b0;
					bit_cnt <= '0;
					state <= LS_WR_DATA; // see RULE5
				end
				LS_RD_DATA:
					if (bit_cnt == BITS_PER_BYTE)
					begin
						state <= LS_RD_ACK;
						drive_low <= 1'b0; // see RULE4
					end
					else
					begin
						tx_shift <= {tx_shift[PORT_W-2:0], 1'b0};
						drive_low <= ~tx_shift[PORT_W-2];
					end
				LS_RD_ACK:
				begin
					// Snapshot was handed over during the high phase
					state <= LS_RD_DATA; // see RULE5
					bit_cnt <= '0;
					tx_shift <= snapshot;
					drive_low <= ~snapshot[PORT_W-1];
				end
				LS_IDLE:
				begin
				end
			endcase
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe = drive_low; // see RULE8, RULE9

	// Port-side synchronisers
	logic [PORT_W-1:0] port_m;
	logic [PORT_W-1:0] port_s;
	logic rd_m;
	logic rd_s;
	logic rd_d;
	logic wr_m;
	logic wr_s;
	logic wr_d;
	logic sclc_m;
	logic sclc_s;
	logic sclc_d;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			port_m <= LATCH_RST;
			port_s <= LATCH_RST;
			rd_m <= 1'b0;
			rd_s <= 1'b0;
			rd_d <= 1'b0;
			wr_m <= 1'b0;
			wr_s <= 1'b0;
			wr_d <= 1'b0;
			sclc_m <= 1'b1;
			sclc_s <= 1'b1;
			sclc_d <= 1'b1;
		end
		else
		begin
			port_m <= port_line_in; // see RULE24
			port_s <= port_m;
			rd_m <= rd_tgl;
			rd_s <= rd_m;
			rd_d <= rd_s;
			wr_m <= wr_tgl;
			wr_s <= wr_m;
			wr_d <= wr_s;
			sclc_m <= scl_in;
			sclc_s <= sclc_m;
			sclc_d <= sclc_s;
		end
	end

	logic rd_evt;
	logic wr_evt;
	logic sclc_fall;
	assign rd_evt = rd_s ^ rd_d;
	assign wr_evt = wr_s ^ wr_d;
	assign sclc_fall = sclc_d & ~sclc_s;

	// Output latch
	logic [PORT_W-1:0] latch;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			latch <= LATCH_RST; // see RULE20
		else if (wr_evt)
			latch <= wr_data; // see RULE12
	end

	// Read snapshot; held stable between requests for the link side
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			snapshot <= LATCH_RST;
		else if (rd_evt)
			snapshot <= port_s; // see RULE12
	end

	// Strong pull-up: armed by a write, dropped at the next clock fall
	logic [PORT_W-1:0] spu;
	logic spu_arm;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			spu <= '0; // see RULE20
			spu_arm <= 1'b0;
		end
		else if (wr_evt)
		begin
			// Only lines that go from low to high need the boost
			spu <= wr_data & ~latch; // see RULE21
			spu_arm <= 1'b0;
		end
		else if (sclc_s && (spu != '0))
			spu_arm <= 1'b1;
		else if (spu_arm && sclc_fall)
		begin
			spu <= '0; // see RULE21
			spu_arm <= 1'b0;
		end
	end

	// Quasi-bidirectional drive: low is strong, high is weak unless boosted
	assign port_line_out = spu; // see RULE11
	assign port_line_oe = ~latch | spu; // see RULE11, RULE22

	// Change detector against a reference taken at the last clear
	logic [PORT_W-1:0] ref_lvl;
	logic int_act;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ref_lvl <= REF_RST;
		else if (rd_evt || wr_evt)
			ref_lvl <= port_s; // see RULE15, RULE16, RULE17
	end

	// A change landing in the clear cycle is absorbed into the new reference
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_act <= 1'b0;
		else if (rd_evt || wr_evt)
			int_act <= 1'b0; // see RULE15, RULE17
		else
			int_act <= (port_s != ref_lvl); // see RULE14, RULE15, RULE18
	end

	assign int_n_out = 1'b0;
	assign int_n_oe = int_act; // see RULE14, RULE19
endmodule

// ### iox_bus_master.sv
// Purpose: Behavioural bus master for the expander bench
// Assumes: Master pushes the clock line; data line is open drain
// Notes: Steps on falling clk edges, 2 us a quarter bit
`timescale 1ns/100ps
module iox_bus_master (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	localparam int Q = 50;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b; // Data moves only with clock low
		wt(Q);
		scl = 1'b1;
		wt(Q);
		r = sda;
		wt(Q);
		scl = 1'b0;
		wt(Q);
	endtask
	task automatic start();
		wt(Q); // Called only on an idle bus
		sda_low = 1'b1;
		wt(Q);
		scl = 1'b0;
		wt(Q);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		wt(Q);
		scl = 1'b1;
		wt(Q);
		sda_low = 1'b0;
		wt(2 * Q);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(!ack, r);
	endtask
endmodule

// ### iox_expander_properties.sv
// Purpose: Port-level checks for the expander
// Assumes: Bus bits last several us
// Notes: Bus checks on link_clk; port and interrupt checks on clk, their own domain
`timescale 1ns/100ps
module iox_expander_properties (
	input wire logic rst,
	input wire logic clk,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [7:0] port_line_in,
	input wire logic [7:0] port_line_out,
	input wire logic [7:0] port_line_oe,
	input wire logic int_n_out,
	input wire logic int_n_oe
);
	logic [3:0] low_cnt;
	logic [3:0] chg_cnt;
	always_ff @(posedge link_clk or posedge rst)
		if (rst)
			low_cnt <= 4'h0;
		else
			low_cnt <= scl_in ? 4'h0 : low_cnt + 4'(low_cnt != 4'hF);
	// Counted on clk so the bound tracks the port synchroniser
	always_ff @(posedge clk or posedge rst)
		if (rst)
			chg_cnt <= 4'h0;
		else
			chg_cnt <= $changed(port_line_in) ? 4'h0 : chg_cnt + 4'(chg_cnt != 4'hF);
	sequence s_hold;
		sda_oe [*8];
	endsequence
	property p_sda_od;
		@(posedge link_clk) disable iff (rst) sda_out == 1'b0;
	endproperty
	a_sda_od: assert property (p_sda_od) else $error("sda driven high");
	property p_int_od;
		@(posedge clk) disable iff (rst) int_n_out == 1'b0;
	endproperty
	a_int_od: assert property (p_int_od) else $error("int driven high");
	property p_drive_edge;
		@(posedge link_clk) disable iff (rst) $rose(sda_oe) |-> !scl_in && low_cnt inside {[5:14]};
	endproperty
	a_drive_edge: assert property (p_drive_edge) else $error("sda pulled off clock fall");
	property p_release_low;
		@(posedge link_clk) disable iff (rst) $fell(sda_oe) |-> !scl_in;
	endproperty
	a_release_low: assert property (p_release_low) else $error("sda freed in clock high");
	property p_hold;
		@(posedge link_clk) disable iff (rst) $rose(sda_oe) |=> s_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("sda pull too short");
	property p_strong_oe;
		@(posedge clk) disable iff (rst) (port_line_out & ~port_line_oe) == 8'h00;
	endproperty
	a_strong_oe: assert property (p_strong_oe) else $error("high without drive");
	property p_pullup_off;
		@(posedge clk) disable iff (rst) port_line_out != 8'h00 && $fell(scl_in) |-> ##[1:6] port_line_out == 8'h00;
	endproperty
	a_pullup_off: assert property (p_pullup_off) else $error("strong pull-up stuck");
	property p_int_rise;
		@(posedge clk) disable iff (rst) $rose(int_n_oe) |-> chg_cnt < 4'h4;
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("int without port change");
endmodule
bind iox_expander iox_expander_properties u_props (.rst, .clk, .link_clk, .scl_in, .sda_out, .sda_oe,
	.port_line_in, .port_line_out, .port_line_oe, .int_n_out, .int_n_oe);

// ### iox_expander_tb_top.sv
// Purpose: Self-checking bench for the expander
// Assumes: Master model paces the bus at 8 us a bit
// Notes: Port pins resolved here with a weak pull-up
`timescale 1ns/100ps
module iox_expander_tb_top;
	import iox_pkg::*;
	localparam logic [PREFIX_W-1:0] PFX = 4'h5; // Arbitrary value
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic scl, m_low, sda_out, sda_oe, int_n_out, int_n_oe, a;
	logic [STRAP_W-1:0] addr_strap = 3'h0;
	logic [7:0] ext_low = 8'h00;
	logic [7:0] port_line_out, port_line_oe, d;
	wire logic sda = !(m_low | sda_oe);
	wire logic [7:0] pins = (port_line_oe & port_line_out) | (~port_line_oe & ~ext_low);
	int bad_count = 0;
	int checks_done = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	initial
	begin
		#3.7;
		forever #6 link_clk = ~link_clk;
	end
	iox_expander #(.ADDR_PREFIX(PFX)) u_dut (.clk, .rst, .link_clk, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_oe, .addr_strap, .port_line_in(pins), .port_line_out, .port_line_oe, .int_n_out, .int_n_oe);
	iox_bus_master u_mst (.clk, .sda, .scl, .sda_low(m_low));
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 70000)
		begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic addr_ok(input logic rd);
		u_mst.start();
		u_mst.wbyte({PFX, addr_strap, rd}, a);
		chk(a, 1'b1);
	endtask
	task automatic t_strap();
		for (int s = 0; s < 8; s++)
		begin
			addr_strap = 3'(s);
			addr_ok(1'b0);
			u_mst.stop();
		end
		u_mst.start();
		u_mst.wbyte({PFX, 3'h2, 1'b0}, a);
		chk(a, 1'b0);
		u_mst.stop();
		$display("t_strap done");
	endtask
	task automatic t_write();
		addr_ok(1'b0);
		u_mst.wbyte(8'h00, a);
		chk(port_line_oe, 8'hFF);
		u_mst.wbyte(8'hFF, a);
		chk(port_line_out, 8'hFF);
		u_mst.wbyte(8'h0F, a);
		chk(a, 1'b1);
		chk(port_line_oe, 8'hF0);
		chk(port_line_out, 8'h00);
		chk(pins, 8'h0F);
		u_mst.stop();
		addr_ok(1'b0);
		for (int i = 0; i < 4; i++)
			u_mst.bit_io(1'b1, a);
		u_mst.stop();
		chk(port_line_oe, 8'hF0);
		$display("t_write done");
	endtask
	task automatic t_int();
		addr_ok(1'b0);
		u_mst.wbyte(8'hFF, a); // Lines high before input use
		u_mst.stop();
		addr_ok(1'b1);
		u_mst.rbyte(1'b0, d);
		u_mst.stop();
		chk(d, 8'hFF);
		chk(int_n_oe, 1'b0);
		ext_low = 8'h3C;
		wt(8);
		chk(int_n_oe, 1'b1);
		ext_low = 8'h00;
		wt(8);
		chk(int_n_oe, 1'b0);
		ext_low = 8'h3C;
		wt(8);
		u_mst.start();
		u_mst.wbyte({PFX, ~addr_strap, 1'b1}, a);
		u_mst.stop();
		chk(int_n_oe, 1'b1);
		addr_ok(1'b1);
		chk(int_n_oe, 1'b0);
		u_mst.rbyte(1'b1, d);
		chk(d, 8'hC3);
		ext_low = 8'hF0;
		wt(8);
		chk(int_n_oe, 1'b1);
		u_mst.rbyte(1'b0, d);
		chk(d, 8'hC3);
		chk(sda, 1'b1);
		u_mst.stop();
		ext_low = 8'h00;
		wt(8);
		chk(int_n_oe, 1'b1);
		// Address byte alone must not clear; the data acknowledge does
		addr_ok(1'b0);
		chk(int_n_oe, 1'b1);
		u_mst.wbyte(8'hFF, a);
		chk(int_n_oe, 1'b0);
		u_mst.stop();
		$display("t_int done");
	endtask
	task automatic t_reset();
		wt(50);
		chk(port_line_oe, 8'h00);
		chk(pins, 8'hFF);
		chk(int_n_oe, 1'b0);
		$display("t_reset done");
	endtask
	initial
	begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_strap();
		t_write();
		t_int();
		end_sim();
	end
endmodule
